// [tsp_regs.svh]
// Register offsets, field positions, reset values and frame counts of the
// transmit serial payload link.
// Assumes it is included by bare name, once per compilation unit or more.
`ifndef TSP_REGS_SVH
`define TSP_REGS_SVH
// -----------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------
`define TSP_MODE_CTRL_OFS 32'h0000_0000
`define TSP_STATUS_OFS 32'h0000_0004
`define TSP_MODE_CTRL_RST 8'h28
`define TSP_TRS_LSB 0
`define TSP_TRS_W 2
`define TSP_TRS_LOOP 2'h0
`define TSP_TRS_SLAVE 2'h1
`define TSP_STAT_SYNC_BIT 3
`define TSP_STAT_FCNT_LSB 16
// -----------------------------------------------------------------------
// Frame shape and buffering
// -----------------------------------------------------------------------
`define TSP_FRAME_BITS 4760
`define TSP_OH_SPACING 85
`define TSP_FIFO_DEPTH 4
`define TSP_FIFO_WIDTH 8
`endif

// [tsp_pkg.sv]
// Types shared by both ends of the transmit serial payload link.
// Assumes tsp_regs.svh is on the include path.
`include "tsp_regs.svh"
package tsp_pkg;
   // --------------------------------------------------------------------
   // Types
   // --------------------------------------------------------------------
   typedef enum logic [2:0] {
      TSP_MODE_OFF = 3'b001,
      TSP_MODE_SLAVE = 3'b010,
      TSP_MODE_MASTER = 3'b100
   } tsp_mode_t;

   typedef enum logic [2:0] {
      TSP_TERM_IDLE = 3'b001,
      TSP_TERM_SYNC = 3'b010,
      TSP_TERM_RUN = 3'b100
   } tsp_term_st_t;

   // Nibble pin or loop timing leaves the serial local-timed path idle.
   function automatic tsp_mode_t tsp_decode_mode(input logic nib,
                                                 input logic [1:0] sel);
      if (nib || sel == `TSP_TRS_LOOP) begin
         return TSP_MODE_OFF;
      end else if (sel == `TSP_TRS_SLAVE) begin
         return TSP_MODE_SLAVE;
      end
      return TSP_MODE_MASTER;
   endfunction : tsp_decode_mode
endpackage : tsp_pkg

// [tsp_link_if.sv]
// Serial payload link between the framer channel and terminal equipment.
// Assumes both ends share one bit clock supplied outside this interface.
`timescale 1ns/1ps
interface tsp_link_if;
   logic serial_payload_in;
   logic frame_reference_in;
   logic last_bit_marker_out;
   logic overhead_indicator_out;

   modport dev (
      input serial_payload_in,
      input frame_reference_in,
      output last_bit_marker_out,
      output overhead_indicator_out
   );
   modport term (
      output serial_payload_in,
      output frame_reference_in,
      input last_bit_marker_out,
      input overhead_indicator_out
   );
endinterface : tsp_link_if

// [tsp_fifo.sv]
// Small valid/ready FIFO held in flip-flops.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`include "tsp_regs.svh"
module tsp_fifo #(
   parameter int WIDTH = `TSP_FIFO_WIDTH,
   parameter int DEPTH = `TSP_FIFO_DEPTH
) (
   input wire logic clk_i,                 // Bit clock.
   input wire logic rst_i,                 // Asynchronous reset.
   input wire logic [WIDTH-1:0] in_data_i, // Word to store.
   input wire logic in_valid_i,            // Word offered.
   output logic in_ready_o,                // Room for a word.
   output logic [WIDTH-1:0] out_data_o,    // Oldest word.
   output logic out_valid_o,               // A word is held.
   input wire logic out_ready_i            // Drain takes the word.
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [AW:0] cnt;
   } fifo_st_t;

   fifo_st_t s_q;
   fifo_st_t s_d;
   logic push;
   logic pop;

   // Full and empty come straight from the count, so neither can lie.
   assign in_ready_o = s_q.cnt != (AW + 1)'(DEPTH);
   assign out_valid_o = s_q.cnt != '0;
   assign out_data_o = s_q.mem[s_q.rd];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Pointers wrap at DEPTH so odd depths work too.
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr] = in_data_i;
         s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
      end
      if (pop) begin
         s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   // State register.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : tsp_fifo

// [tsp_dev.sv]
// Framer channel end of the transmit serial payload link, local timing.
// Assumes the link bit clock is CLK_SYS_I and the terminal drives its
// outputs synchronously to it; software reaches registers over AHB-Lite.
`timescale 1ns/1ps
`include "tsp_regs.svh"
module tsp_dev #(
   parameter int FRAME_BITS = `TSP_FRAME_BITS,
   parameter int OH_SPACING = `TSP_OH_SPACING
) (
   input wire logic CLK_SYS_I,             // Local transmit input clock.
   input wire logic RST_I,                 // Asynchronous reset.
   input wire logic HSEL_I,                // AHB slave select.
   input wire logic [31:0] HADDR_I,        // AHB address.
   input wire logic [1:0] HTRANS_I,        // AHB transfer type.
   input wire logic HWRITE_I,              // AHB write.
   input wire logic [2:0] HSIZE_I,         // AHB size, word only.
   input wire logic [31:0] HWDATA_I,       // AHB write data.
   input wire logic HREADY_I,              // AHB bus ready.
   output logic HREADYOUT_O,               // Never stalls.
   output logic HRESP_O,                   // Always OKAY.
   output logic [31:0] HRDATA_O,           // Registered read data.
   input wire logic NIBBLE_INTERFACE_PIN_I, // High selects nibble path.
   tsp_link_if.dev link,                   // Link to terminal equipment.
   output logic PAYLOAD_BIT_O,             // Captured payload bit.
   output logic PAYLOAD_VALID_O,           // One-cycle pulse per bit.
   output logic FRAME_START_O,             // Pulse with a frame's bit 0.
   output logic [2:0] MODE_O               // Decoded mode, one-hot.
);
   localparam int PW = $clog2(FRAME_BITS);
   localparam int BW = $clog2(OH_SPACING);

   // --------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] mode_ctrl;
      tsp_pkg::tsp_mode_t mode;
      logic wr_pend;
      logic [31:0] addr;
      logic [31:0] rdata;
      logic ref_q;
      logic synced;
      logic [PW-1:0] pos;
      logic [BW-1:0] blk;
      logic [15:0] frames;
      logic pbit;
      logic pvalid;
      logic sof;
   } dev_st_t;

   dev_st_t s_q;
   dev_st_t s_d;
   tsp_pkg::tsp_mode_t mode;
   logic ref_rise;
   logic active;
   logic overhead;
   logic [PW-1:0] eff_pos;
   logic [BW-1:0] eff_blk;
   logic oh_w;
   logic mark_w;

   // --------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------
   // The bus never inserts wait states, so every transfer is OKAY.
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;
   assign HRDATA_O = s_q.rdata;
   assign PAYLOAD_BIT_O = s_q.pbit;
   assign PAYLOAD_VALID_O = s_q.pvalid;
   assign FRAME_START_O = s_q.sof;
   assign MODE_O = s_q.mode;
   assign link.overhead_indicator_out = oh_w;
   assign link.last_bit_marker_out = mark_w;

   // --------------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------------
   // Register file, mode decode and the frame position counter.
   always_comb begin
      s_d = s_q;
      oh_w = 1'b0;
      mark_w = 1'b0;

      // A data phase write lands before any read of the same edge, so a
      // read that follows a write back to back sees the new value.
      if (s_q.wr_pend && s_q.addr == `TSP_MODE_CTRL_OFS) begin
         s_d.mode_ctrl = HWDATA_I[7:0];
      end
      s_d.wr_pend = 1'b0;
      if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
         s_d.wr_pend = HWRITE_I;
         s_d.addr = HADDR_I;
         if (!HWRITE_I) begin
            unique case (HADDR_I)
               `TSP_MODE_CTRL_OFS: begin
                  s_d.rdata = {24'h00_0000, s_d.mode_ctrl};
               end
               `TSP_STATUS_OFS: begin
                  s_d.rdata = {s_q.frames, 12'h000, s_q.synced, s_q.mode};
               end
               default: begin
                  s_d.rdata = 32'h0000_0000;
               end
            endcase
         end
      end

      mode = tsp_pkg::tsp_decode_mode(NIBBLE_INTERFACE_PIN_I,
         s_q.mode_ctrl[`TSP_TRS_LSB +: `TSP_TRS_W]);
      s_d.mode = mode;

      // Only slave mode looks at the reference; master mode keeps its own
      // count whatever the terminal drives there.
      ref_rise = (mode == tsp_pkg::TSP_MODE_SLAVE) &&
         link.frame_reference_in && !s_q.ref_q;
      s_d.ref_q = link.frame_reference_in;

      // Slave mode stays silent until the first reference edge, since any
      // earlier overhead pulse would point at a slot the terminal ignores.
      active = (mode == tsp_pkg::TSP_MODE_MASTER) ||
         ((mode == tsp_pkg::TSP_MODE_SLAVE) && (s_q.synced || ref_rise));
      eff_pos = ref_rise ? '0 : s_q.pos;
      eff_blk = ref_rise ? '0 : s_q.blk;
      overhead = eff_blk == BW'(OH_SPACING - 1);

      // The last slot of every block is overhead; no payload is taken.
      s_d.pbit = link.serial_payload_in;
      s_d.pvalid = active && !overhead;
      s_d.sof = active && !overhead && eff_pos == '0;

      if (active) begin
         oh_w = eff_blk == BW'(OH_SPACING - 2);
         mark_w = (mode == tsp_pkg::TSP_MODE_MASTER) &&
            eff_pos == PW'(FRAME_BITS - 1);
         s_d.synced = 1'b1;
         s_d.pos = (eff_pos == PW'(FRAME_BITS - 1)) ? '0 :
            eff_pos + 1'b1;
         s_d.blk = overhead ? '0 : eff_blk + 1'b1;
         if (eff_pos == PW'(FRAME_BITS - 1)) begin
            s_d.frames = s_q.frames + 1'b1;
         end
      end else begin
         s_d.pos = '0;
         s_d.blk = '0;
      end

      // A mode change restarts framing from a clean position.
      if (mode != s_q.mode) begin
         s_d.synced = 1'b0;
         s_d.pos = '0;
         s_d.blk = '0;
         s_d.pvalid = 1'b0;
         s_d.sof = 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // State register
   // --------------------------------------------------------------------
   // Every field resets to a constant; the mode decodes as idle.
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         s_q <= '0;
         s_q.mode_ctrl <= `TSP_MODE_CTRL_RST;
         s_q.mode <= tsp_pkg::TSP_MODE_OFF;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : tsp_dev

// [tsp_term.sv]
// Terminal equipment end of the transmit serial payload link.
// Assumes CLK_SYS_I is the bit clock shared with the framer channel and
// that user words are sent least significant bit first.
`timescale 1ns/1ps
`include "tsp_regs.svh"
module tsp_term #(
   parameter int FRAME_BITS = `TSP_FRAME_BITS,
   parameter int WIDTH = `TSP_FIFO_WIDTH,
   parameter int DEPTH = `TSP_FIFO_DEPTH
) (
   input wire logic CLK_SYS_I,          // Shared bit clock.
   input wire logic RST_I,              // Asynchronous reset.
   input wire logic ENABLE_I,           // Run the link.
   input wire logic DEVICE_MASTER_I,    // Framer times the frames.
   input wire logic [WIDTH-1:0] PUSH_DATA_I, // Payload word.
   input wire logic PUSH_VALID_I,       // Word offered.
   output logic PUSH_READY_O,           // Buffer has room.
   output logic UNDERRUN_O,             // Pulse when a zero was padded.
   tsp_link_if.term link                // Link to the framer channel.
);
   localparam int PW = $clog2(FRAME_BITS);
   localparam int CW = $clog2(WIDTH + 1);

   typedef struct packed {
      tsp_pkg::tsp_term_st_t st;
      logic [PW-1:0] pos;
      logic [WIDTH-1:0] sh;
      logic [CW-1:0] cnt;
      logic dat;
      logic fref;
      logic under;
   } term_st_t;

   term_st_t s_q;
   term_st_t s_d;
   logic take;
   logic [WIDTH-1:0] f_data;
   logic f_valid;
   logic f_ready;

   // --------------------------------------------------------------------
   // Payload buffer
   // --------------------------------------------------------------------
   // The buffer drains only as the framer takes bits, so overhead gaps
   // push back to the user through PUSH_READY_O.
   tsp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
      .clk_i(CLK_SYS_I),
      .rst_i(RST_I),
      .in_data_i(PUSH_DATA_I),
      .in_valid_i(PUSH_VALID_I),
      .in_ready_o(PUSH_READY_O),
      .out_data_o(f_data),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready)
   );

   assign link.serial_payload_in = s_q.dat;
   assign link.frame_reference_in = s_q.fref;
   assign UNDERRUN_O = s_q.under;
   assign f_ready = take && s_q.cnt == '0;

   // --------------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------------
   // All outputs change just after the rising edge.
   always_comb begin
      s_d = s_q;
      take = 1'b0;
      s_d.fref = 1'b0;
      s_d.under = 1'b0;
      unique case (s_q.st)
         tsp_pkg::TSP_TERM_IDLE: begin
            s_d.dat = 1'b0;
            if (ENABLE_I) begin
               if (DEVICE_MASTER_I) begin
                  s_d.st = tsp_pkg::TSP_TERM_SYNC;
               end else begin
                  s_d.st = tsp_pkg::TSP_TERM_RUN;
                  s_d.pos = '0;
                  s_d.fref = 1'b1;
                  take = 1'b1;
               end
            end
         end
         tsp_pkg::TSP_TERM_SYNC: begin
            if (link.last_bit_marker_out) begin
               s_d.st = tsp_pkg::TSP_TERM_RUN;
               take = 1'b1;
            end
         end
         tsp_pkg::TSP_TERM_RUN: begin
            // An overhead pulse means the next slot carries no payload.
            take = !link.overhead_indicator_out;
            s_d.dat = 1'b0;
            s_d.pos = (s_q.pos == PW'(FRAME_BITS - 1)) ? '0 :
               s_q.pos + 1'b1;
            s_d.fref = !DEVICE_MASTER_I && s_d.pos == '0;
         end
      endcase

      if (take) begin
         if (s_q.cnt != '0) begin
            s_d.dat = s_q.sh[0];
            s_d.sh = s_q.sh >> 1;
            s_d.cnt = s_q.cnt - 1'b1;
         end else if (f_valid) begin
            s_d.dat = f_data[0];
            s_d.sh = f_data >> 1;
            s_d.cnt = CW'(WIDTH - 1);
         end else begin
            s_d.dat = 1'b0;
            s_d.under = 1'b1;
         end
      end

      if (!ENABLE_I) begin
         s_d.st = tsp_pkg::TSP_TERM_IDLE;
         s_d.dat = 1'b0;
         s_d.fref = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         s_q <= '0;
         s_q.st <= tsp_pkg::TSP_TERM_IDLE;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : tsp_term

// [tsp_link_monitor.sv]
// Concurrent checks on the serial payload link between the two ends.
// Assumes one shared bit clock and the active-high asynchronous reset.
`timescale 1ns/1ps
`include "tsp_regs.svh"
module tsp_link_monitor #(
   parameter int FRAME_BITS = `TSP_FRAME_BITS,
   parameter int OH_SPACING = `TSP_OH_SPACING
) (
   input wire logic CLK_SYS_I,              // Shared bit clock.
   input wire logic RST_I,                  // Asynchronous reset.
   input wire logic serial_payload_in,      // Payload bit to the framer.
   input wire logic frame_reference_in,     // Frame start from terminal.
   input wire logic last_bit_marker_out,    // Last bit of a frame.
   input wire logic overhead_indicator_out  // Overhead slot is next.
);
   localparam int FB = FRAME_BITS;
   localparam int OHS = OH_SPACING;
   localparam int OHD = OH_SPACING - 2;

   // Cycles since the last marker and reference pulse, zero before the
   // first; a full frame is too long for a plain delay, so it is counted.
   logic [15:0] mark_gap_q;
   logic [15:0] ref_gap_q;

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         mark_gap_q <= 16'h0000;
         ref_gap_q <= 16'h0000;
      end else begin
         if (last_bit_marker_out) begin
            mark_gap_q <= 16'h0001;
         end else if (mark_gap_q != 16'h0000) begin
            mark_gap_q <= mark_gap_q + 16'h0001;
         end
         if (frame_reference_in) begin
            ref_gap_q <= 16'h0001;
         end else if (ref_gap_q != 16'h0000) begin
            ref_gap_q <= ref_gap_q + 16'h0001;
         end
      end
   end

   // --------------------------------------------------------------------
   // Timing checks
   // --------------------------------------------------------------------
   // All checks share the bit clock and go quiet while reset is high.
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);

   property p_oh_single;
      overhead_indicator_out |=> !overhead_indicator_out;
   endproperty
   a_oh_single: assert property (p_oh_single)
      else $error("overhead pulse longer than one cycle");

   // Every block of the frame carries one overhead slot.
   property p_oh_period;
      overhead_indicator_out |-> ##OHS overhead_indicator_out;
   endproperty
   a_oh_period: assert property (p_oh_period)
      else $error("overhead pulses not evenly spaced");

   property p_mark_single;
      last_bit_marker_out |=> !last_bit_marker_out;
   endproperty
   a_mark_single: assert property (p_mark_single)
      else $error("marker longer than one cycle");

   // The last bit is itself an overhead slot, so its warning came first.
   property p_mark_after_oh;
      last_bit_marker_out |-> $past(overhead_indicator_out);
   endproperty
   a_mark_after_oh: assert property (p_mark_after_oh)
      else $error("marker without overhead warning");

   property p_mark_period;
      (mark_gap_q != 16'h0000) |->
         ((mark_gap_q == 16'(FB)) == last_bit_marker_out);
   endproperty
   a_mark_period: assert property (p_mark_period)
      else $error("marker not one frame apart");

   property p_ref_single;
      frame_reference_in |=> !frame_reference_in;
   endproperty
   a_ref_single: assert property (p_ref_single)
      else $error("frame reference longer than one cycle");

   property p_ref_starts_frame;
      $rose(frame_reference_in) |-> ##OHD overhead_indicator_out;
   endproperty
   a_ref_starts_frame: assert property (p_ref_starts_frame)
      else $error("frame not restarted at reference edge");

   property p_ref_period;
      (ref_gap_q != 16'h0000) |->
         ((ref_gap_q == 16'(FB)) == frame_reference_in);
   endproperty
   a_ref_period: assert property (p_ref_period)
      else $error("frame reference not one frame apart");

   // No payload is offered in the slot after an overhead warning.
   property p_oh_slot_empty;
      overhead_indicator_out |=> !serial_payload_in;
   endproperty
   a_oh_slot_empty: assert property (p_oh_slot_empty)
      else $error("payload bit driven into overhead slot");
endmodule : tsp_link_monitor

// [tb_top.sv]
// Self-checking bench joining the framer end and the terminal end.
// Assumes the design files and tsp_regs.svh are compiled alongside.
`timescale 1ns/1ps
`include "tsp_regs.svh"
module tb_top;
   localparam int FB = 20;
   localparam int OHS = 5;
   localparam int PAY = FB - FB / OHS;
   localparam int NB = 6;
   localparam int LIMIT = 20000;
   localparam logic [7:0] PAT [NB] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0,
                                        8'h96, 8'h81};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready, hresp, pay_bit, pay_vld, fstart, pready, under;
   logic [31:0] hrdata;
   logic [2:0] mode;
   logic nib = 1'b0;
   logic ena = 1'b0;
   logic dev_master = 1'b0;
   logic [7:0] pdata = 8'h0;
   logic pvalid = 1'b0;
   logic started = 1'b0;
   logic cap[$];
   int fsi[$];
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;
   int n_under = 0;

   // --------------------------------------------------------------------
   // Clock, design and checker
   // --------------------------------------------------------------------
   // A 200 MHz bit clock shared by both ends.
   initial begin
      forever #2.5 clk = ~clk;
   end

   tsp_link_if tsp_link_if_inst ();
   tsp_dev #(.FRAME_BITS(FB), .OH_SPACING(OHS)) tsp_dev_inst (
      .CLK_SYS_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
      .HWDATA_I(hwdata), .HREADY_I(hready), .HREADYOUT_O(hready),
      .HRESP_O(hresp), .HRDATA_O(hrdata), .NIBBLE_INTERFACE_PIN_I(nib),
      .link(tsp_link_if_inst), .PAYLOAD_BIT_O(pay_bit),
      .PAYLOAD_VALID_O(pay_vld), .FRAME_START_O(fstart), .MODE_O(mode));
   tsp_term #(.FRAME_BITS(FB), .WIDTH(8), .DEPTH(4)) tsp_term_inst (
      .CLK_SYS_I(clk), .RST_I(rst), .ENABLE_I(ena),
      .DEVICE_MASTER_I(dev_master), .PUSH_DATA_I(pdata),
      .PUSH_VALID_I(pvalid), .PUSH_READY_O(pready), .UNDERRUN_O(under),
      .link(tsp_link_if_inst));
   tsp_link_monitor #(.FRAME_BITS(FB), .OH_SPACING(OHS))
      tsp_link_monitor_inst (
      .CLK_SYS_I(clk), .RST_I(rst),
      .serial_payload_in(tsp_link_if_inst.serial_payload_in),
      .frame_reference_in(tsp_link_if_inst.frame_reference_in),
      .last_bit_marker_out(tsp_link_if_inst.last_bit_marker_out),
      .overhead_indicator_out(tsp_link_if_inst.overhead_indicator_out));

   // --------------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------------
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // One single AHB-Lite word transfer; read data is taken at the end.
   task automatic ahb(input logic wr, input logic [31:0] addr,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= addr;
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask : ahb

   // Ready is looked at mid-cycle, since it may change at the edge.
   task automatic push(input logic [7:0] d);
      @(posedge clk);
      pdata <= d;
      pvalid <= 1'b1;
      @(negedge clk);
      while (pready !== 1'b1) @(negedge clk);
      @(posedge clk);
      pvalid <= 1'b0;
   endtask : push

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      ena <= 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   function automatic logic [2:0] exp_mode(input logic p,
                                           input logic [1:0] s);
      if (p || s == 2'h0) return 3'h1;
      return (s == 2'h1) ? 3'h2 : 3'h4;
   endfunction : exp_mode

   // Fills the buffer until it refuses, then streams three frames.
   task automatic run_stream(input logic master, input string name);
      logic [31:0] rd;
      logic eb;
      do_reset();
      dev_master <= master;
      cap.delete();
      fsi.delete();
      started = 1'b0;
      n_under = 0;
      ahb(1'b1, `TSP_MODE_CTRL_OFS, master ? 32'h2A : 32'h29, rd);
      for (int i = 0; i < 4; i++) push(PAT[i]);
      @(negedge clk);
      chk("push_ready_full", {31'h0, pready}, 32'h0);
      @(posedge clk);
      ena <= 1'b1;
      for (int i = 4; i < NB; i++) push(PAT[i]);
      while (cap.size() < NB * 8) @(posedge clk);
      for (int i = 0; i < NB * 8; i++) begin
         eb = PAT[i / 8][i % 8];
         chk("payload_bit", {31'h0, cap[i]}, {31'h0, eb});
      end
      for (int k = 0; k < 3; k++) begin
         chk("frame_start", fsi[k], k * PAY);
      end
      repeat (2 * FB) @(posedge clk);
      chk("underrun", {31'h0, n_under > 0}, 32'h1);
      $display("test %s done", name);
   endtask : run_stream

   // --------------------------------------------------------------------
   // Capture and timeout
   // --------------------------------------------------------------------
   // Sampled mid-cycle so registered outputs have settled.
   always @(negedge clk) begin
      if (!rst && pay_vld === 1'b1) begin
         if (fstart === 1'b1 && ena === 1'b1) started = 1'b1;
         if (started && fstart === 1'b1) fsi.push_back(cap.size());
         if (started) cap.push_back(pay_bit);
      end
      if (under === 1'b1) n_under++;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_fail++;
         summarize();
      end
   end

   // --------------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------------
   initial begin
      logic [31:0] rd;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      ahb(1'b0, `TSP_MODE_CTRL_OFS, 32'h0, rd);
      chk("mode_ctrl_reset", rd, 32'h28);
      chk("mode_reset", {29'h0, mode}, 32'h1);
      ahb(1'b1, `TSP_MODE_CTRL_OFS, 32'hFFFF_FFA5, rd);
      ahb(1'b0, `TSP_MODE_CTRL_OFS, 32'h0, rd);
      chk("mode_ctrl_rw", rd, 32'hA5);
      ahb(1'b1, 32'h10, 32'hFFFF_FFFF, rd);
      ahb(1'b0, 32'h10, 32'h0, rd);
      chk("unmapped", rd, 32'h0);
      ahb(1'b1, `TSP_STATUS_OFS, 32'hFFFF_FFFF, rd);
      ahb(1'b0, `TSP_STATUS_OFS, 32'h0, rd);
      chk("status_ro", {29'h0, rd[2:0]}, 32'h2);
      chk("hresp", {31'h0, hresp}, 32'h0);
      $display("test registers done");
      // Every pin level against every timing select value.
      for (int p = 0; p < 2; p++) begin
         for (int s = 0; s < 4; s++) begin
            do_reset();
            nib <= p[0];
            ahb(1'b1, `TSP_MODE_CTRL_OFS, {24'h0, 6'h0A, s[1:0]}, rd);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("mode", {29'h0, mode}, {29'h0, exp_mode(p[0], s[1:0])});
            ahb(1'b0, `TSP_STATUS_OFS, 32'h0, rd);
            chk("status_mode", {29'h0, rd[2:0]},
                {29'h0, exp_mode(p[0], s[1:0])});
         end
      end
      nib <= 1'b0;
      $display("test mode decode done");
      run_stream(1'b1, "master");
      run_stream(1'b0, "slave");
      summarize();
   end
endmodule : tb_top
